// ### hdl/lcdrc_pkg.sv
// constants, encodings and register map of the lcd row/column driver core
package lcdrc_pkg;
  // oscillator, frame and division figures
  localparam int FOSC_HZ        = 12288;
  localparam int FSYNC_HZ       = 64;
  localparam int FRAME_OSC      = FOSC_HZ / FSYNC_HZ;
  localparam int DIV_STD        = 6;
  localparam int DIV_24         = 8;
  localparam int FRAME_CLK_STD  = FRAME_OSC / DIV_STD;
  localparam int FRAME_CLK_24   = FRAME_OSC / DIV_24;
  // output and memory geometry
  localparam int NOUT           = 40;
  localparam int NFIXED         = 8;
  localparam int NPROG          = 24;
  localparam int NROWMAX        = 32;
  localparam int NCOLS          = 40;
  localparam int NBANKS         = 4;
  localparam int RAM_DEPTH      = NBANKS * NCOLS;
  localparam int RAM_AW         = 8;
  localparam int BYTE_W         = 8;
  localparam logic [5:0] LAST_COL = 6'h27;
  localparam logic [3:0] HW_SUBADDR = 4'h0;
  // register byte offsets
  localparam logic [3:0] OFS_CFG  = 4'h0;
  localparam logic [3:0] OFS_TX   = 4'h4;
  localparam logic [3:0] OFS_RX   = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;
  localparam int TX_START_BIT     = 8;
  // multiplex rate codes
  localparam logic [1:0] MUX32 = 2'h0;
  localparam logic [1:0] MUX8  = 2'h1;
  localparam logic [1:0] MUX16 = 2'h2;
  localparam logic [1:0] MUX24 = 2'h3;
  // display status codes
  localparam logic [1:0] DISP_BLANK   = 2'h0;
  localparam logic [1:0] DISP_NORMAL  = 2'h1;
  localparam logic [1:0] DISP_ALLON   = 2'h2;
  localparam logic [1:0] DISP_INVERSE = 2'h3;
  // access modes
  localparam logic [1:0] ACC_CHAR = 2'h0;
  localparam logic [1:0] ACC_HALF = 2'h1;
  localparam logic [1:0] ACC_FULL = 2'h2;
  // command byte fields
  localparam int CONT_BIT              = 7;
  localparam logic [1:0] OP_MODE       = 2'h2;
  localparam logic [2:0] OP_SELECT     = 3'h6;
  localparam logic [2:0] OP_BANKGRP    = 3'h7;
  localparam logic [1:0] OP_START_BANK = 2'h3;
  localparam logic T_ROW_MODE          = 1'b1;
  // bus read handshake states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_DONE = 2'b11
  } lcdrc_rd_e;
endpackage

// ### hdl/lcdrc_ram.sv
// display memory with one read/write port and one read-only scan port
`timescale 1ns/1ps
module lcdrc_ram #(
  parameter int AW    = 8,
  parameter int DW    = 8,
  parameter int DEPTH = 160
) (
  input  wire logic          sys_clk_i,
  input  wire logic [AW-1:0] a_addr_i,
  input  wire logic          a_we_i,
  input  wire logic [DW-1:0] a_wdata_i,
  output logic      [DW-1:0] a_rdata_o,
  input  wire logic [AW-1:0] b_addr_i,
  output logic      [DW-1:0] b_rdata_o
);
  logic [DW-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_chk
    $error("lcdrc_ram: depth exceeds address range");
  end

  // host port: write and registered read
  always_ff @(posedge sys_clk_i) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    a_rdata_o <= mem[a_addr_i];
  end

  // scan port: registered read
  always_ff @(posedge sys_clk_i) begin
    b_rdata_o <= mem[b_addr_i];
  end
endmodule

// ### hdl/lcdrc_top.sv
// lcd row/column driver timing, output sequencing, display memory access
`timescale 1ns/1ps
//
// Function
// - cascade clock is oscillator divided by six, or by eight at 1:24
// - with oscillator pin held high, timing runs from clock supplied on cascade pin
// - frame sync period is a whole number of cascade clock periods
// - 12288 Hz oscillator gives 64 Hz frame at every multiplex rate
// - first eight outputs rows, last eight columns, middle 24 programmable by eights
// - row select steps from output zero through multiplex-rate rows, rest columns
// - row mode drives all programmable outputs as rows, fixed columns idle
// - in row mode 1:16 selects k and k+16 together, 1:8 selects four outputs together
// - memory holds four banks of forty bytes, byte is eight rows of a column
// - memory columns 0 to 7 stored but never shown, others map directly
// - data stored or returned only when subaddress counter matches zero
// - byte port receives always, transmits only in mixed mode
// - memory access happens only in mixed mode
// - access mode bits choose character, half-graphic or full-graphic order
// - host sets subaddress, column and bank before moving data
// - subaddress counter advances between devices, wraps 15 to 0
// - stored rows are scanned continuously, count set by mux rate bits
// - display status bits pick blank, all on, normal or inverse
// - top bank bits choose bank shown at the top of the display
// - reset gives blank, 1:32, row mode, bank 0, pointer 0, character, subaddress 0
// - command top bit set means another command follows, clear means data
// - each data byte advances data pointer, subaddress counter steps when column wraps past last
module lcdrc_top #(
  parameter int EXT_DETECT = 64
) (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        oscillator_resistor_input_i,
  input  wire logic        casc_clk_i,
  output logic             casc_clk_o,
  output logic             casc_clk_oe_n_o,
  output logic             sync_n_o,
  output logic [7:0]       fixed_row_outputs_o,
  output logic [23:0]      programmable_outputs_o,
  output logic [23:0]      programmable_is_row_o,
  output logic [7:0]       fixed_column_outputs_o
);
  localparam int IW = $clog2(EXT_DETECT + 1);

  if (EXT_DETECT < 16) begin : g_chk
    $error("lcdrc_top: EXT_DETECT must cover several oscillator periods");
  end

  // rows scanned for a multiplex code
  function automatic logic [5:0] mux_rows(input logic [1:0] m);
    case (m)
      lcdrc_pkg::MUX8:  mux_rows = 6'h08;
      lcdrc_pkg::MUX16: mux_rows = 6'h10;
      lcdrc_pkg::MUX24: mux_rows = 6'h18;
      default:          mux_rows = 6'h20;
    endcase
  endfunction

  // cascade clock periods per row so that each frame has a fixed length
  function automatic logic [2:0] ticks_per_row(input logic [1:0] m);
    int fr;
    fr = (m == lcdrc_pkg::MUX24) ? lcdrc_pkg::FRAME_CLK_24 : lcdrc_pkg::FRAME_CLK_STD;
    ticks_per_row = 3'(fr / int'(mux_rows(m)));
  endfunction

  // byte address of a bank and column
  function automatic logic [7:0] ram_addr(input logic [1:0] b, input logic [5:0] x);
    ram_addr = 8'(b * lcdrc_pkg::NCOLS) + {2'h0, x};
  endfunction

  // output idx selected by row r, repeated every rows outputs
  function automatic logic row_hit(input logic [5:0] idx, input logic [4:0] r,
                                   input logic [5:0] rows);
    logic [7:0] a;
    logic [7:0] s;
    a = {2'h0, idx};
    s = {3'h0, r};
    row_hit = (a == s) || (a == s + {2'h0, rows}) || (a == s + {1'h0, rows, 1'h0})
           || (a == s + {2'h0, rows} + {1'h0, rows, 1'h0});
  endfunction

  // pointer step after one data byte: {subaddr, bank, x}
  function automatic logic [11:0] advance(input logic [1:0] g, input logic [3:0] sa,
                                          input logic [1:0] bk, input logic [5:0] x);
    logic xstep;
    logic [1:0] nb;
    logic [3:0] ns;
    logic [5:0] nx;
    xstep = 1'b1;
    nb = bk;
    if (g == lcdrc_pkg::ACC_HALF) begin
      xstep = bk[0];
      nb = bk ^ 2'h1;
    end else if (g != lcdrc_pkg::ACC_CHAR) begin
      xstep = (bk == 2'h3);
      nb = bk + 2'h1;
    end
    ns = sa;
    nx = x;
    if (xstep) begin
      nx = (x >= lcdrc_pkg::LAST_COL) ? 6'h00 : x + 6'h01;
      ns = (x >= lcdrc_pkg::LAST_COL) ? sa + 4'h1 : sa;
    end
    advance = {ns, nb, nx};
  endfunction

  logic            osc_s1, osc_s2, osc_s3, cpin_s1, cpin_s2, cpin_s3;
  logic [IW-1:0]   idle_cnt;
  logic            ext_mode, clk_drv;
  logic [2:0]      div_cnt, tick_cnt;
  logic [4:0]      row_cnt, fetch_row;
  logic            fbusy, fv;
  logic [5:0]      fcol, fcol_d;
  logic [39:0]     col_buf, drv, is_row, next_drv, next_is_row;
  logic            sync_n;
  logic [1:0]      mux_rate_bits, display_status_bits, top_bank_bits;
  logic [1:0]      access_mode_bits, bank_select_bits;
  logic            row_mode, cmd_phase;
  logic [3:0]      subaddr;
  logic [5:0]      ptr_x;
  logic [1:0]      next_mux, next_disp, next_top, next_acc, next_bank;
  logic            next_row_mode, next_cmd_phase;
  logic [3:0]      next_sub;
  logic [5:0]      next_x;
  lcdrc_pkg::lcdrc_rd_e rd_state;
  logic [31:0]     rdata;
  logic [7:0]      ram_q, scan_q;

  // pin synchronisers, third stage only for edge finding
  always_ff @(posedge sys_clk_i) begin
    osc_s1  <= oscillator_resistor_input_i;
    osc_s2  <= osc_s1;
    osc_s3  <= osc_s2;
    cpin_s1 <= casc_clk_i;
    cpin_s2 <= cpin_s1;
    cpin_s3 <= cpin_s2;
  end

  wire       osc_rise  = osc_s2 & ~osc_s3;
  wire       cpin_rise = cpin_s2 & ~cpin_s3;
  wire [2:0] half_div  = 3'(((mux_rate_bits == lcdrc_pkg::MUX24) ?
                             lcdrc_pkg::DIV_24 : lcdrc_pkg::DIV_STD) / 2);
  wire       div_wrap  = (div_cnt == half_div - 3'h1);
  wire       tick_int  = osc_rise & ~ext_mode & div_wrap & ~clk_drv;
  wire       tick      = ext_mode ? cpin_rise : tick_int;
  wire [5:0] rows      = mux_rows(mux_rate_bits);
  wire [2:0] tpr       = ticks_per_row(mux_rate_bits);
  wire       step      = tick & (tick_cnt == tpr - 3'h1);
  wire [1:0] fbank     = top_bank_bits + fetch_row[4:3];

  // oscillator held high means clock comes in on the cascade pin
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      idle_cnt <= '0;
      ext_mode <= 1'b0;
    end else begin
      idle_cnt <= osc_rise ? '0 : (idle_cnt == IW'(EXT_DETECT)) ? idle_cnt : idle_cnt + 1'b1;
      ext_mode <= (idle_cnt == IW'(EXT_DETECT)) & osc_s2;
    end
  end

  // cascade clock toggles every half division of the oscillator
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      div_cnt <= 3'h0;
      clk_drv <= 1'b0;
    end else if (osc_rise && !ext_mode) begin
      div_cnt <= div_wrap ? 3'h0 : div_cnt + 3'h1;
      clk_drv <= div_wrap ? ~clk_drv : clk_drv;
    end
  end

  // row stepping, frame of rows times ticks per row
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      tick_cnt  <= 3'h0;
      row_cnt   <= 5'h00;
      fetch_row <= 5'h00;
      sync_n    <= 1'b1;
    end else if (tick) begin
      tick_cnt  <= step ? 3'h0 : tick_cnt + 3'h1;
      if (step) begin
        row_cnt   <= fetch_row;
        fetch_row <= ({1'b0, fetch_row} >= rows - 6'h01) ? 5'h00 : fetch_row + 5'h01;
      end
      sync_n <= ~(step && fetch_row == 5'h00);
    end
  end

  // scan fetch of forty columns of the next row
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      fbusy  <= 1'b0;
      fcol   <= 6'h00;
      fv     <= 1'b0;
      fcol_d <= 6'h00;
    end else begin
      fbusy  <= step | (fbusy & (fcol != lcdrc_pkg::LAST_COL));
      fcol   <= step ? 6'h00 : fbusy ? fcol + 6'h01 : fcol;
      fv     <= fbusy;
      fcol_d <= fcol;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (fv) begin
      col_buf[fcol_d] <= scan_q[fetch_row[2:0]];
    end
  end

  // driver pattern for the row about to show
  always_comb begin
    for (int i = 0; i < lcdrc_pkg::NOUT; i++) begin
      next_is_row[i] = (i < lcdrc_pkg::NROWMAX) && (row_mode || (i < int'(rows)));
      if (next_is_row[i]) begin
        next_drv[i] = row_hit(6'(i), fetch_row, rows);
      end else if (!row_mode && i >= lcdrc_pkg::NFIXED) begin
        case (display_status_bits)
          lcdrc_pkg::DISP_NORMAL:  next_drv[i] = col_buf[i];
          lcdrc_pkg::DISP_ALLON:   next_drv[i] = 1'b1;
          lcdrc_pkg::DISP_INVERSE: next_drv[i] = ~col_buf[i];
          default:                 next_drv[i] = 1'b0;
        endcase
      end else begin
        next_drv[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      drv    <= '0;
      is_row <= {8'h00, 32'hFFFFFFFF};
    end else if (step) begin
      drv    <= next_drv;
      is_row <= next_is_row;
    end
  end

  // bus decode
  wire        tx_wr    = avs_write_i && avs_address_i == lcdrc_pkg::OFS_TX && avs_byteenable_i[0];
  wire        tx_start = avs_writedata_i[lcdrc_pkg::TX_START_BIT] && avs_byteenable_i[1];
  wire [7:0]  tx_byte  = avs_writedata_i[7:0];
  wire        tx_cmd   = tx_wr && (tx_start || cmd_phase);
  wire        tx_data  = tx_wr && !tx_start && !cmd_phase;
  wire        rx_acc   = avs_read_i && rd_state == lcdrc_pkg::RD_DONE
                         && avs_address_i == lcdrc_pkg::OFS_RX;
  // only mixed mode, matching subaddress, valid column
  wire        acc_ok   = !row_mode && subaddr == lcdrc_pkg::HW_SUBADDR
                         && ptr_x <= lcdrc_pkg::LAST_COL;
  wire        ram_we   = tx_data && acc_ok;
  wire        rx_step  = rx_acc && !row_mode;
  wire [11:0] adv      = advance(access_mode_bits, subaddr, bank_select_bits, ptr_x);

  // command decode and pointer advance
  always_comb begin
    next_mux       = mux_rate_bits;
    next_disp      = display_status_bits;
    next_top       = top_bank_bits;
    next_acc       = access_mode_bits;
    next_bank      = bank_select_bits;
    next_row_mode  = row_mode;
    next_cmd_phase = cmd_phase;
    next_sub       = subaddr;
    next_x         = ptr_x;
    if (tx_cmd) begin
      next_cmd_phase = tx_byte[lcdrc_pkg::CONT_BIT];
      if (!tx_byte[6]) begin
        next_x = tx_byte[5:0];
      end else if (tx_byte[6:5] == lcdrc_pkg::OP_MODE) begin
        next_row_mode = (tx_byte[4] == lcdrc_pkg::T_ROW_MODE);
        next_disp     = tx_byte[3:2];
        next_mux      = tx_byte[1:0];
      end else if (tx_byte[6:4] == lcdrc_pkg::OP_SELECT) begin
        next_sub = tx_byte[3:0];
      end else if (tx_byte[3:2] == lcdrc_pkg::OP_START_BANK) begin
        next_top = tx_byte[1:0];
      end else begin
        next_acc  = tx_byte[3:2];
        next_bank = tx_byte[1:0];
      end
    end else if (tx_data || rx_step) begin
      {next_sub, next_bank, next_x} = adv;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      mux_rate_bits       <= lcdrc_pkg::MUX32;
      display_status_bits <= lcdrc_pkg::DISP_BLANK;
      top_bank_bits       <= 2'h0;
      access_mode_bits    <= lcdrc_pkg::ACC_CHAR;
      bank_select_bits    <= 2'h0;
      row_mode            <= 1'b1;
      cmd_phase           <= 1'b0;
      subaddr             <= 4'h0;
      ptr_x               <= 6'h00;
    end else begin
      mux_rate_bits       <= next_mux;
      display_status_bits <= next_disp;
      top_bank_bits       <= next_top;
      access_mode_bits    <= next_acc;
      bank_select_bits    <= next_bank;
      row_mode            <= next_row_mode;
      cmd_phase           <= next_cmd_phase;
      subaddr             <= next_sub;
      ptr_x               <= next_x;
    end
  end

  lcdrc_ram #(
    .AW    (lcdrc_pkg::RAM_AW),
    .DW    (lcdrc_pkg::BYTE_W),
    .DEPTH (lcdrc_pkg::RAM_DEPTH)
  ) u_ram (
    .sys_clk_i (sys_clk_i),
    .a_addr_i  (ram_addr(bank_select_bits, ptr_x)),
    .a_we_i    (ram_we),
    .a_wdata_i (tx_byte),
    .a_rdata_o (ram_q),
    .b_addr_i  (ram_addr(fbank, fcol)),
    .b_rdata_o (scan_q)
  );

  // read word selection
  always_comb begin
    case (avs_address_i)
      lcdrc_pkg::OFS_CFG:  rdata = {7'h00, cmd_phase, ext_mode, ~row_mode, display_status_bits,
                                    mux_rate_bits, top_bank_bits, access_mode_bits,
                                    bank_select_bits, subaddr, 2'h0, ptr_x};
      lcdrc_pkg::OFS_RX:   rdata = {23'h000000, ~row_mode, acc_ok ? ram_q : 8'hFF};
      lcdrc_pkg::OFS_STAT: rdata = {24'h000000, fbusy, ~sync_n, row_cnt, 1'b0};
      default:             rdata = 32'h00000000;
    endcase
  end

  // reads take two wait cycles so memory data is settled
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_state       <= lcdrc_pkg::RD_IDLE;
      avs_readdata_o <= 32'h00000000;
    end else begin
      case (rd_state)
        lcdrc_pkg::RD_IDLE: rd_state <= avs_read_i ? lcdrc_pkg::RD_WAIT : lcdrc_pkg::RD_IDLE;
        lcdrc_pkg::RD_WAIT: begin
          rd_state       <= lcdrc_pkg::RD_DONE;
          avs_readdata_o <= rdata;
        end
        default:            rd_state <= lcdrc_pkg::RD_IDLE;
      endcase
    end
  end

  // pin and status outputs
  assign avs_waitrequest_o      = avs_read_i && rd_state != lcdrc_pkg::RD_DONE;
  assign casc_clk_o             = clk_drv;
  assign casc_clk_oe_n_o        = ext_mode;
  assign sync_n_o               = sync_n;
  assign fixed_row_outputs_o    = drv[7:0];
  assign programmable_outputs_o = drv[31:8];
  assign programmable_is_row_o  = is_row[31:8];
  assign fixed_column_outputs_o = drv[39:32];

  property p_div_ratio;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (mux_rate_bits == lcdrc_pkg::MUX24) |-> half_div == 3'h4;
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("wrong divider at 1:24");

  property p_sync_frame;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $fell(sync_n) |-> row_cnt == 5'h00 && $past(tick);
  endproperty
  a_sync_frame: assert property (p_sync_frame) else $error("sync not at frame start");

  property p_fixed_roles;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      is_row[7:0] == 8'hFF && is_row[39:32] == 8'h00;
  endproperty
  a_fixed_roles: assert property (p_fixed_roles) else $error("fixed outputs changed role");

  property p_mux8_mixed;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(step) && !$past(row_mode) && $past(mux_rate_bits) == lcdrc_pkg::MUX8
        |-> is_row[39:8] == 32'h00000000;
  endproperty
  a_mux8_mixed: assert property (p_mux8_mixed) else $error("mixed 1:8 row mask wrong");

  property p_row_mode_cols;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(step) && $past(row_mode) |-> drv[39:32] == 8'h00 && is_row[31:0] == 32'hFFFFFFFF;
  endproperty
  a_row_mode_cols: assert property (p_row_mode_cols) else $error("row mode outputs wrong");

  property p_split16;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(step) && $past(row_mode) && $past(mux_rate_bits) == lcdrc_pkg::MUX16
        |-> drv[15:0] == drv[31:16];
  endproperty
  a_split16: assert property (p_split16) else $error("1:16 halves differ");

  property p_store_match;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      ram_we |-> subaddr == lcdrc_pkg::HW_SUBADDR && !row_mode;
  endproperty
  a_store_match: assert property (p_store_match) else $error("store outside mixed or match");

  property p_blank;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      $past(step) && $past(display_status_bits) == lcdrc_pkg::DISP_BLANK
        |-> (drv & ~is_row) == 40'h0000000000;
  endproperty
  a_blank: assert property (p_blank) else $error("blank shows column data");

  property p_cont_bit;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      tx_cmd && !tx_byte[lcdrc_pkg::CONT_BIT] ##1 !tx_wr ##1 tx_wr |-> !tx_cmd || tx_start;
  endproperty
  a_cont_bit: assert property (p_cont_bit) else $error("byte after last command not data");

  property p_advance;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      (tx_data || rx_step) && access_mode_bits == lcdrc_pkg::ACC_CHAR
        && ptr_x == lcdrc_pkg::LAST_COL
        |=> ptr_x == 6'h00 && subaddr == $past(subaddr) + 4'h1;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer wrap or subaddress step wrong");
endmodule

// ### verification/lcdrc_link_model.sv
// oscillator source and external clock source facing the driver core
`timescale 1ns/1ps
module lcdrc_link_model (
  input  wire logic ext_mode_i,
  output logic      osc_o,
  output logic      ext_clk_o
);
  logic osc_run;
  initial begin
    osc_run   = 1'b0;
    ext_clk_o = 1'b0;
  end
  // oscillator toggling at the 48 ns link rate
  always #24 osc_run = ~osc_run;
  initial begin
    #7;
    forever #24 ext_clk_o = ~ext_clk_o;
  end
  assign osc_o = ext_mode_i ? 1'b1 : osc_run;
endmodule

// ### verification/lcdrc_top_tb.sv
// self-checking bench for the lcd row/column driver core
`timescale 1ns/1ps
module lcdrc_top_tb;
  logic        sys_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        osc;
  logic        ext_clk;
  logic        ext_mode = 1'b0;
  logic        casc_pin;
  logic        casc_clk_o;
  logic        casc_clk_oe_n_o;
  logic        sync_n_o;
  logic [7:0]  fixed_row_outputs_o;
  logic [23:0] programmable_outputs_o;
  logic [23:0] programmable_is_row_o;
  logic [7:0]  fixed_column_outputs_o;
  logic [31:0] q;
  int          errors = 0;
  int          comparisons = 0;
  logic [7:0]  cmds [6] = '{8'h56, 8'h55, 8'h45, 8'h46, 8'h47, 8'h44};
  logic [23:0] rows [6] = '{24'hFFFFFF, 24'hFFFFFF, 24'h0, 24'h0000FF, 24'h00FFFF, 24'hFFFFFF};
  // driver outputs 0 to 15
  wire  [15:0] low16 = {programmable_outputs_o[7:0], fixed_row_outputs_o};

  // clock
  always #2.5 sys_clk_i = ~sys_clk_i;
  // cascade pin level from both drivers
  assign casc_pin = casc_clk_oe_n_o ? ext_clk : casc_clk_o;

  lcdrc_link_model lcdrc_link_model_inst (.ext_mode_i(ext_mode), .osc_o(osc), .ext_clk_o(ext_clk));
  lcdrc_top #(.EXT_DETECT(32)) lcdrc_top_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .oscillator_resistor_input_i(osc),
    .casc_clk_i(casc_pin), .casc_clk_o(casc_clk_o), .casc_clk_oe_n_o(casc_clk_oe_n_o),
    .sync_n_o(sync_n_o), .fixed_row_outputs_o(fixed_row_outputs_o),
    .programmable_outputs_o(programmable_outputs_o),
    .programmable_is_row_o(programmable_is_row_o),
    .fixed_column_outputs_o(fixed_column_outputs_o));

  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one bus cycle, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int   n;
    logic w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      w = avs_waitrequest_o;
      r = avs_readdata_o;
      n++;
    end while (w !== 1'b0 && n < 50);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (w !== 1'b0) begin
      errors++;
      final_report();
    end
    @(posedge sys_clk_i);
  endtask

  task automatic tx(input logic s, input logic [7:0] b);
    logic [31:0] r;
    bus(1'b1, lcdrc_pkg::OFS_TX, {23'h0, s, b}, r);
  endtask

  // set a mode, then time cascade ticks and frame length
  task automatic measure(input logic [7:0] cmd, input int lo, input int ticks,
                         input logic [23:0] exp_rows);
    int   n;
    int   gap;
    int   cnt;
    int   run;
    logic pc;
    logic ps;
    tx(1'b1, cmd);
    pc = casc_pin;
    ps = sync_n_o;
    gap = 0;
    cnt = 0;
    run = 0;
    for (n = 0; n < 8000 && run < 2; n++) begin
      @(negedge sys_clk_i);
      gap++;
      if (casc_pin === 1'b1 && pc === 1'b0) begin
        if (run == 1) check({31'h0, gap >= lo && gap <= lo + 3}, 32'h1);
        gap = 0;
        cnt++;
      end
      if (sync_n_o === 1'b0 && ps === 1'b1) begin
        if (run == 1) check(cnt, ticks);
        cnt = 0;
        run++;
      end
      pc = casc_pin;
      ps = sync_n_o;
    end
    if (run < 2) begin
      errors++;
      final_report();
    end
    check({8'h0, programmable_is_row_o}, {8'h0, exp_rows});
    @(posedge sys_clk_i);
  endtask

  // cut a hang short
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    errors++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    bus(1'b0, lcdrc_pkg::OFS_CFG, 32'h0, q);
    check(q & 32'h007FFFFF, 32'h0);
    bus(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    bus(1'b0, lcdrc_pkg::OFS_RX, 32'h0, q);
    check({23'h0, q[8:0]}, 32'h0FF);
    measure(8'h54, 56, 32, 24'hFFFFFF);
    check({24'h0, fixed_column_outputs_o}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      measure(cmds[i], (i == 4) ? 75 : 56, (i == 4) ? 24 : 32, rows[i]);
      // row mode split screen at 1:16, four sets at 1:8
      if (i == 0) check({16'h0, programmable_outputs_o[23:8]}, {16'h0, low16});
      if (i == 1) check({8'h0, programmable_outputs_o}, {8'h0, {3{fixed_row_outputs_o}}});
    end
    // write two bytes in full-graphic order, then read them back
    tx(1'b1, 8'h88);
    tx(1'b0, 8'h78);
    tx(1'b0, 8'hA5);
    tx(1'b0, 8'h5A);
    // read back in full-graphic, then in half-graphic order
    for (int m = 0; m < 2; m++) begin
      tx(1'b1, 8'h88);
      tx(1'b0, (m == 0) ? 8'h78 : 8'h74);
      bus(1'b0, lcdrc_pkg::OFS_RX, 32'h0, q);
      check({23'h0, q[8:0]}, 32'h1A5);
      bus(1'b0, lcdrc_pkg::OFS_RX, 32'h0, q);
      check({23'h0, q[8:0]}, 32'h15A);
      bus(1'b0, lcdrc_pkg::OFS_CFG, 32'h0, q);
      check(q & 32'hFF3F, (m == 0) ? 32'hA008 : 32'h4009);
    end
    // foreign subaddress at the last column, then wrap
    tx(1'b1, 8'hF0);
    tx(1'b0, 8'hEF);
    tx(1'b0, 8'h27);
    bus(1'b0, lcdrc_pkg::OFS_RX, 32'h0, q);
    check({23'h0, q[8:0]}, 32'h1FF);
    bus(1'b0, lcdrc_pkg::OFS_CFG, 32'h0, q);
    check(q & 32'h0F3F, 32'h0);
    // hold the oscillator pin high for external clocking
    ext_mode <= 1'b1;
    repeat (200) @(posedge sys_clk_i);
    bus(1'b0, lcdrc_pkg::OFS_CFG, 32'h0, q);
    check({31'h0, q[23]}, 32'h1);
    check({31'h0, casc_clk_oe_n_o}, 32'h1);
    measure(8'h44, 9, 32, 24'hFFFFFF);
    final_report();
  end
endmodule
